// ---- src/kpi_pkg.sv ----
// constants, types and helpers for the keyboard pin interrupt block
package kpi_pkg;

  localparam int unsigned KPI_NUM_PINS = 8;
  localparam int unsigned KPI_NUM_SEL  = 4;
  localparam int unsigned KPI_ADR_W    = 4;
  localparam int unsigned KPI_DAT_W    = 32;

  // register byte offsets on the bus
  localparam logic [KPI_ADR_W-1:0] KPI_OFS_STATUS_CONTROL = 4'h0;
  localparam logic [KPI_ADR_W-1:0] KPI_OFS_PIN_ENABLE     = 4'h4;

  // field positions in status_control_reg
  localparam int unsigned KPI_SC_POL_LSB  = 4;
  localparam int unsigned KPI_SC_POL_MSB  = 7;
  localparam int unsigned KPI_SC_FLAG_BIT = 3;
  localparam int unsigned KPI_SC_ACK_BIT  = 2;
  localparam int unsigned KPI_SC_IE_BIT   = 1;
  localparam int unsigned KPI_SC_MODE_BIT = 0;

  // byte lane that carries both registers
  localparam int unsigned KPI_LANE0 = 0;

  // reset values
  localparam logic [KPI_NUM_PINS-1:0] KPI_PIN_EN_RST = 8'h00;
  localparam logic [3:0]              KPI_POL_RST    = 4'h0;
  localparam logic [KPI_NUM_PINS-1:0] KPI_SAMP_RST   = 8'h00;
  localparam logic [KPI_DAT_W-1:0]    KPI_DAT_ZERO   = 32'h0000_0000;

  // inputs 3..0 have fixed falling/low polarity
  localparam logic [3:0] KPI_POL_FIXED = 4'h0;

  // edge-only (0) or edge-and-level (1) detection
  typedef enum logic {
    KPI_MODE_EDGE       = 1'b0,
    KPI_MODE_EDGE_LEVEL = 1'b1
  } kpi_mode_type;

  typedef struct packed {
    logic [3:0]   pol_hi;
    logic         key_irq_enable;
    kpi_mode_type edge_level_mode;
  } kpi_ctrl_type;

  typedef struct packed {
    logic [KPI_NUM_PINS-1:0] cur;
    logic [KPI_NUM_PINS-1:0] prev;
  } kpi_samp_type;

  // asserted level per pin: polarity 1 means high asserted
  function automatic logic [KPI_NUM_PINS-1:0] kpi_asserted(
    input logic [KPI_NUM_PINS-1:0] pins,
    input logic [KPI_NUM_PINS-1:0] pol
  );
    kpi_asserted = ~(pins ^ pol);
  endfunction

endpackage

// ---- src/kpi_sampler.sv ----
// two-stage sampler of the key pins on the bus clock
`timescale 1ns/10ps
module kpi_sampler
  import kpi_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic [KPI_NUM_PINS-1:0] pins_i,
  output kpi_samp_type                 samp_o
);

  logic [KPI_NUM_PINS-1:0] cur_r;
  logic [KPI_NUM_PINS-1:0] prev_r;

  // one bus cycle apart, so an edge spans two consecutive samples
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_r  <= KPI_SAMP_RST;
      prev_r <= KPI_SAMP_RST;
    end else if (ce_i) begin
      cur_r  <= pins_i;
      prev_r <= cur_r;
    end
  end

  assign samp_o.cur  = cur_r;
  assign samp_o.prev = prev_r;

endmodule

// ---- src/kpi_top.sv ----
// keyboard pin interrupt detector with classic wishbone registers
`timescale 1ns/10ps
module kpi_top
  import kpi_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [KPI_ADR_W-1:0]    wb_adr_i,
  input  wire logic [KPI_NUM_SEL-1:0]  wb_sel_i,
  input  wire logic [KPI_DAT_W-1:0]    wb_dat_i,
  output logic      [KPI_DAT_W-1:0]    wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic [KPI_NUM_PINS-1:0] key_pins_i,
  input  wire logic                    stop_mode_i,
  output logic                         irq_o,
  output logic                         wake_o
);

  logic [KPI_NUM_PINS-1:0] pin_enable_reg_r;
  kpi_ctrl_type            ctrl_r;
  logic                    key_event_flag_r;
  logic                    ack_r;
  logic [KPI_DAT_W-1:0]    rdata_r;

  kpi_samp_type            samp;
  logic [KPI_NUM_PINS-1:0] polarity_select;
  logic [KPI_NUM_PINS-1:0] act_cur;
  logic [KPI_NUM_PINS-1:0] act_prev;
  logic [KPI_NUM_PINS-1:0] act_live;
  logic [KPI_NUM_PINS-1:0] pin_detect_enable;
  logic [KPI_NUM_PINS-1:0] edge_vec;
  logic                    edge_any;
  logic                    others_quiet;
  logic                    edge_qual;
  logic                    level_hold;
  logic                    flag_set;
  logic                    bus_req;
  logic                    wr_commit;
  logic                    sel_sc;
  logic                    sel_pe;
  logic                    flag_acknowledge;
  logic [KPI_DAT_W-1:0]    rdata_nxt;

  // ------------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------------
  kpi_sampler u_sampler (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .pins_i (key_pins_i),
    .samp_o (samp)
  );

  // low four inputs stay falling/low whatever is written
  assign polarity_select = {ctrl_r.pol_hi, KPI_POL_FIXED};

  assign act_cur  = kpi_asserted(samp.cur, polarity_select);
  assign act_prev = kpi_asserted(samp.prev, polarity_select);
  assign act_live = kpi_asserted(key_pins_i, polarity_select);

  // disabled pins are masked out of every term below
  assign pin_detect_enable = pin_enable_reg_r;

  // edge: deasserted in one bus cycle, asserted in the next
  assign edge_vec = pin_detect_enable & act_cur & ~act_prev;
  assign edge_any = |edge_vec;

  // enabled pins without an edge were and still are deasserted
  assign others_quiet = ~|(pin_detect_enable & ~edge_vec & (act_cur | act_prev));

  always_comb begin
    unique case (ctrl_r.edge_level_mode)
      KPI_MODE_EDGE:       edge_qual = edge_any;
      KPI_MODE_EDGE_LEVEL: edge_qual = edge_any & others_quiet;
    endcase
  end

  assign level_hold = (ctrl_r.edge_level_mode == KPI_MODE_EDGE_LEVEL) &&
                      (|(pin_detect_enable & act_cur));

  assign flag_set = edge_qual | level_hold;

  // ------------------------------------------------------------------
  // wishbone slave: ack one cycle after the strobe, write at the ack edge
  // ------------------------------------------------------------------
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign wr_commit = bus_req & wb_we_i & ack_r & wb_sel_i[KPI_LANE0];
  assign sel_sc    = (wb_adr_i == KPI_OFS_STATUS_CONTROL);
  assign sel_pe    = (wb_adr_i == KPI_OFS_PIN_ENABLE);

  assign flag_acknowledge = wr_commit & sel_sc & wb_dat_i[KPI_SC_ACK_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  // unmapped offsets read zero; acknowledge bit always reads zero
  always_comb begin
    rdata_nxt = KPI_DAT_ZERO;
    if (sel_sc) begin
      rdata_nxt[KPI_SC_POL_MSB:KPI_SC_POL_LSB] = ctrl_r.pol_hi;
      rdata_nxt[KPI_SC_FLAG_BIT]               = key_event_flag_r;
      rdata_nxt[KPI_SC_ACK_BIT]                = 1'b0;
      rdata_nxt[KPI_SC_IE_BIT]                 = ctrl_r.key_irq_enable;
      rdata_nxt[KPI_SC_MODE_BIT]               = ctrl_r.edge_level_mode;
    end else if (sel_pe) begin
      rdata_nxt[KPI_NUM_PINS-1:0] = pin_enable_reg_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= KPI_DAT_ZERO;
    end else if (ce_i) begin
      if (bus_req & ~ack_r & ~wb_we_i) begin
        rdata_r <= rdata_nxt;
      end else if (~bus_req) begin
        rdata_r <= KPI_DAT_ZERO;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_enable_reg_r <= KPI_PIN_EN_RST;
    end else if (ce_i && wr_commit && sel_pe) begin
      pin_enable_reg_r <= wb_dat_i[KPI_NUM_PINS-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r.pol_hi          <= KPI_POL_RST;
      ctrl_r.key_irq_enable  <= 1'b0;
      ctrl_r.edge_level_mode <= KPI_MODE_EDGE;
    end else if (ce_i && wr_commit && sel_sc) begin
      ctrl_r.pol_hi          <= wb_dat_i[KPI_SC_POL_MSB:KPI_SC_POL_LSB];
      ctrl_r.key_irq_enable  <= wb_dat_i[KPI_SC_IE_BIT];
      ctrl_r.edge_level_mode <= kpi_mode_type'(wb_dat_i[KPI_SC_MODE_BIT]);
    end
  end

  // ------------------------------------------------------------------
  // event flag: a set in the acknowledge cycle wins over the clear
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_event_flag_r <= 1'b0;
    end else if (ce_i) begin
      if (flag_set) begin
        key_event_flag_r <= 1'b1;
      end else if (flag_acknowledge) begin
        key_event_flag_r <= 1'b0;
      end
    end
  end

  assign irq_o = key_event_flag_r & ctrl_r.key_irq_enable;

  // clocks may be halted in stop: pure level path from the pins
  assign wake_o = stop_mode_i & (|(pin_detect_enable & act_live));

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_IRQ_FOLLOWS_FLAG: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_o == (key_event_flag_r && ctrl_r.key_irq_enable))
    else $error("irq does not follow flag and enable");

  AST_DISABLED_NO_SET: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && (pin_enable_reg_r == KPI_PIN_EN_RST) && !key_event_flag_r
    |=> !key_event_flag_r)
    else $error("flag set with no pin enabled");

  AST_FALL_SETS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && pin_enable_reg_r[0] && samp.prev[0] && !samp.cur[0]
    && ctrl_r.edge_level_mode == KPI_MODE_EDGE
    |=> key_event_flag_r)
    else $error("falling edge on input 0 missed");

  AST_RISE_SETS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && pin_enable_reg_r[KPI_SC_POL_LSB] && ctrl_r.pol_hi[0]
    && !samp.prev[KPI_SC_POL_LSB] && samp.cur[KPI_SC_POL_LSB]
    && ctrl_r.edge_level_mode == KPI_MODE_EDGE
    |=> key_event_flag_r)
    else $error("rising edge on input 4 missed");

  AST_LEVEL_HOLDS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && ctrl_r.edge_level_mode == KPI_MODE_EDGE_LEVEL
    && (|(pin_enable_reg_r & act_cur))
    |=> key_event_flag_r)
    else $error("flag dropped while a pin stays asserted");

  AST_ACK_CLEARS: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && flag_acknowledge && !edge_any
    && ctrl_r.edge_level_mode == KPI_MODE_EDGE
    |=> !key_event_flag_r)
    else $error("acknowledge did not clear the flag");

  AST_LEVEL_EDGE_QUIET: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !key_event_flag_r && ctrl_r.edge_level_mode == KPI_MODE_EDGE_LEVEL
    && !(|(pin_enable_reg_r & act_cur))
    |=> !key_event_flag_r)
    else $error("flag set in level mode with no asserted pin");

  AST_ACK_READS_ZERO: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> !wb_dat_o[KPI_SC_ACK_BIT])
    else $error("acknowledge bit read back as one");

  AST_FIXED_POLARITY: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wr_commit && sel_sc
    |=> polarity_select[KPI_SC_POL_LSB-1:0] == KPI_POL_FIXED)
    else $error("low inputs took a written polarity");

  AST_POL_WRITE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wr_commit && sel_sc
    |=> ctrl_r.pol_hi == $past(wb_dat_i[KPI_SC_POL_MSB:KPI_SC_POL_LSB]))
    else $error("polarity select not stored");

  AST_STOP_WAKE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    stop_mode_i && (|(pin_enable_reg_r & act_live)) |-> wake_o)
    else $error("no wake-up for asserted pin in stop");

  AST_RESET_CLEAR: assert property (
    @(posedge clk_i)
    $past(rst_i) |-> !key_event_flag_r && !irq_o
    && pin_enable_reg_r == KPI_PIN_EN_RST && ctrl_r.key_irq_enable == 1'b0)
    else $error("state not cleared by reset");

  AST_SYNC_EDGE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !key_event_flag_r && ctrl_r.edge_level_mode == KPI_MODE_EDGE
    && !flag_acknowledge && $stable(samp.cur) && (samp.cur == samp.prev)
    |=> !key_event_flag_r)
    else $error("flag set with no edge on the samples");

  AST_EDGE_SETS_FLAG: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && edge_qual |=> key_event_flag_r ##1 1'b1)
    else $error("qualifying edge did not set the flag");

  AST_BUS_ACK: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o || !ce_i)
    else $error("bus ack not one cycle after request");

endmodule

// ---- verif/kpi_key_model.sv ----
// key switch lines on pull resistors, pressed keys driven by the bench
`timescale 1ns/10ps
module kpi_key_model
  import kpi_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic [KPI_NUM_PINS-1:0] rest_i,
  input  wire logic [KPI_NUM_PINS-1:0] press_i,
  output logic      [KPI_NUM_PINS-1:0] pins_o
);
  // a released key returns to its pulled rest level
  always_ff @(posedge clk_i) begin
    pins_o <= rest_i ^ press_i;
  end
endmodule

// ---- verif/kpi_top_bench.sv ----
// self-checking bench for the keyboard pin interrupt block
`timescale 1ns/10ps
module kpi_top_bench
  import kpi_pkg::*;
;
  typedef struct packed {
    logic [7:0] sc;
    logic [7:0] en;
    logic [7:0] rest;
    logic [7:0] press;
    logic       flag;
  } kpi_row_type;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    ce_i = 1'b1;
  logic                    wb_cyc_i = 1'b0;
  logic                    wb_stb_i = 1'b0;
  logic                    wb_we_i = 1'b0;
  logic [KPI_ADR_W-1:0]    wb_adr_i = 4'h0;
  logic [KPI_NUM_SEL-1:0]  wb_sel_i = 4'h0;
  logic [KPI_DAT_W-1:0]    wb_dat_i = 32'h0000_0000;
  logic [KPI_DAT_W-1:0]    wb_dat_o;
  logic                    wb_ack_o;
  logic [KPI_NUM_PINS-1:0] key_pins;
  logic                    stop_mode_i = 1'b0;
  logic                    irq_o;
  logic                    wake_o;
  logic [7:0]              rest = 8'hff;
  logic [7:0]              press = 8'h00;
  int                      bad_count = 0;
  int                      n_tests = 0;
  kpi_row_type             rows [8];
  kpi_row_type             r;

  always #10 clk_i = ~clk_i;

  kpi_top u_kpi_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .key_pins_i(key_pins),
    .stop_mode_i(stop_mode_i), .irq_o(irq_o), .wake_o(wake_o)
  );
  kpi_key_model u_kpi_key_model (
    .clk_i(clk_i), .rest_i(rest), .press_i(press), .pins_o(key_pins)
  );

  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb_go(input logic [3:0] adr, input logic we, input logic [7:0] dat,
                       input logic [3:0] sel, output logic [31:0] rd);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h00_0000, dat};
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k == 20) begin
      bad_count++;
      results();
    end
  endtask

  task automatic wb_wr(input logic [3:0] adr, input logic [7:0] dat, input logic [3:0] sel);
    logic [31:0] rd;
    wb_go(adr, 1'b1, dat, sel, rd);
  endtask

  task automatic wb_rd(input logic [3:0] adr, input logic [7:0] exp, input string nm);
    logic [31:0] rd;
    wb_go(adr, 1'b0, 8'h00, 4'hf, rd);
    chk(nm, {24'h00_0000, exp}, rd);
  endtask

  initial begin
    // sc, enables, rest levels, pressed keys, expected flag
    rows[0] = '{8'h02, 8'h01, 8'hff, 8'h01, 1'b1};
    rows[1] = '{8'h00, 8'h01, 8'hff, 8'h01, 1'b1};
    rows[2] = '{8'h02, 8'h02, 8'hff, 8'h01, 1'b0};
    rows[3] = '{8'h12, 8'h10, 8'hef, 8'h10, 1'b1};
    rows[4] = '{8'h02, 8'h10, 8'hff, 8'h10, 1'b1};
    rows[5] = '{8'hf2, 8'h01, 8'hfe, 8'h01, 1'b0};
    rows[6] = '{8'h03, 8'h01, 8'hff, 8'h01, 1'b1};
    rows[7] = '{8'h03, 8'h03, 8'hff, 8'h03, 1'b1};
    tick(6);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      rest <= r.rest;
      wb_wr(KPI_OFS_STATUS_CONTROL, r.sc, 4'h1);
      wb_wr(KPI_OFS_PIN_ENABLE, r.en, 4'h1);
      press <= r.press;
      tick(5);
      chk("irq", {31'h0, r.flag & r.sc[1]}, {31'h0, irq_o});
      wb_rd(KPI_OFS_STATUS_CONTROL, {r.sc[7:4], r.flag, 1'b0, r.sc[1:0]}, "sc");
      press <= 8'h00;
      tick(5);
      wb_wr(KPI_OFS_PIN_ENABLE, 8'h00, 4'h1);
      wb_wr(KPI_OFS_STATUS_CONTROL, 8'h04, 4'h1);
    end
    // acknowledge while the key is still held
    rest <= 8'hff;
    wb_wr(KPI_OFS_STATUS_CONTROL, 8'h02, 4'h1);
    wb_wr(KPI_OFS_PIN_ENABLE, 8'h01, 4'h1);
    press <= 8'h01;
    tick(5);
    wb_wr(KPI_OFS_STATUS_CONTROL, 8'h06, 4'h1);
    wb_rd(KPI_OFS_STATUS_CONTROL, 8'h02, "sc_edge_ack");
    chk("irq_ack", 32'h0, {31'h0, irq_o});
    // level mode keeps the flag while held
    wb_wr(KPI_OFS_STATUS_CONTROL, 8'h03, 4'h1);
    wb_wr(KPI_OFS_STATUS_CONTROL, 8'h07, 4'h1);
    wb_rd(KPI_OFS_STATUS_CONTROL, 8'h0b, "sc_level_hold");
    press <= 8'h00;
    tick(5);
    wb_wr(KPI_OFS_STATUS_CONTROL, 8'h07, 4'h1);
    wb_rd(KPI_OFS_STATUS_CONTROL, 8'h03, "sc_level_free");
    // stop mode: clock enable low, level wake-up
    stop_mode_i <= 1'b1;
    press <= 8'h01;
    tick(2);
    ce_i <= 1'b0;
    tick(2);
    chk("wake_on", 32'h1, {31'h0, wake_o});
    press <= 8'h00;
    tick(3);
    chk("wake_off", 32'h0, {31'h0, wake_o});
    ce_i <= 1'b1;
    stop_mode_i <= 1'b0;
    press <= 8'h01;
    tick(3);
    chk("wake_run", 32'h0, {31'h0, wake_o});
    press <= 8'h00;
    // refused writes: lane 0 off, unmapped place
    wb_wr(KPI_OFS_PIN_ENABLE, 8'h55, 4'he);
    wb_rd(KPI_OFS_PIN_ENABLE, 8'h01, "en_sel");
    wb_wr(4'h8, 8'hff, 4'h1);
    wb_rd(4'h8, 8'h00, "unmapped");
    // second reset in mid-run
    wb_wr(KPI_OFS_PIN_ENABLE, 8'hff, 4'h1);
    wb_wr(KPI_OFS_STATUS_CONTROL, 8'hf3, 4'h1);
    rst_i <= 1'b1;
    tick(6);
    rst_i <= 1'b0;
    wb_rd(KPI_OFS_STATUS_CONTROL, 8'h00, "sc_rst");
    wb_rd(KPI_OFS_PIN_ENABLE, 8'h00, "en_rst");
    chk("irq_rst", 32'h0, {31'h0, irq_o});
    results();
  end
endmodule
